// ==== rtl/bpws_pkg.sv ====
// Package for the pattern word store: map, modes, constants
package bpws_pkg;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_BYTE0     = 8'h3C;
  localparam logic [7:0]  OFF_BYTE1     = 8'h3D;
  localparam logic [7:0]  OFF_BYTE2     = 8'h3E;
  localparam logic [7:0]  OFF_BYTE3     = 8'h3F;
  localparam logic [7:0]  OFF_CTRL      = 8'h34;
  localparam logic [7:0]  OFF_COUNT     = 8'h33;
  localparam logic [7:0]  OFF_STATUS    = 8'h35;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  COUNT_RST     = 8'h00;
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_LEN_LSB  = 2;
  localparam int          CTRL_EN_BIT   = 6;
  localparam logic [4:0]  HALF_TOP      = 5'h0F;
  localparam logic [4:0]  HIGH_BASE     = 5'h10;
  localparam logic [4:0]  REP_TOP_BASE  = 5'h10;

  typedef enum logic [1:0]
  {
    BPWS_PRBS = 2'b00,
    BPWS_REP  = 2'b01,
    BPWS_ALT  = 2'b10
  } bpws_mode_t;
endpackage

// ==== rtl/bpws_store.sv ====
// Four-byte pattern store with registered read data
`timescale 1ns/1ns
`default_nettype none
module bpws_store
  import bpws_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Access
  input  wire logic [1:0]  idx,
  input  wire logic [7:0]  wdata,
  input  wire logic        we,
  output logic      [7:0]  rdata,
  // Whole store
  output logic      [31:0] bits
);
  logic [7:0] mem_r [4];
  logic [7:0] mem_nxt [4];
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      mem_nxt[i] = mem_r[i];
    if (we)
      mem_nxt[idx] = wdata;
    rd_nxt = mem_r[idx];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        mem_r[i] <= BYTE_RST;
      rd_r <= BYTE_RST;
    end
    else
    begin
      mem_r <= mem_nxt;
      rd_r  <= rd_nxt;
    end
  end

  assign rdata = rd_r;
  assign bits  = {mem_r[3], mem_r[2], mem_r[1], mem_r[0]};
endmodule // bpws_store
`default_nettype wire

// ==== rtl/bpws_top.sv ====
// Pattern word store with serial generator and receive checker
`timescale 1ns/1ns
`default_nettype none
module bpws_top
  import bpws_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  // Bit stream, one bit per channel clock
  output logic                   tx_bit,
  input  wire logic              rx_bit,
  output logic                   rx_sync,
  output logic                   rx_err
);
  import bpws_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] bits;
  logic [7:0]  st_rdata;
  logic        st_we;
  logic [7:0]  ctrl_r, ctrl_nxt, cnt_r, cnt_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        sel_st_r, sel_st_nxt;
  logic        is_st;
  // Receive side state and the registered transmit bit; sync and error flags read back through the status register
  logic        rx_m_r, rx_s_r, sync_r, sync_nxt, rx_err_r, rx_err_nxt, tx_r, tx_nxt;

  assign is_st = (addr[7:2] == OFF_BYTE0[7:2]);
  assign st_we = wr && is_st;

  bpws_store u_store
  (
    .clk   (clk),
    .srst  (srst),
    .idx   (addr[1:0]),
    .wdata (wdata),
    .we    (st_we),
    .rdata (st_rdata),
    .bits  (bits)
  );

  // Read data of other registers is muxed behind the store's registered output
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    cnt_nxt    = cnt_r;
    sel_st_nxt = rd && is_st;
    rdata_nxt  = 8'h00;
    if (wr && addr == OFF_CTRL)
      ctrl_nxt = wdata;
    if (wr && addr == OFF_COUNT)
      cnt_nxt = wdata;
    if (rd && addr == OFF_CTRL)
      rdata_nxt = ctrl_r;
    if (rd && addr == OFF_COUNT)
      rdata_nxt = cnt_r;
    if (rd && addr == OFF_STATUS)
      rdata_nxt = {6'h00, rx_err_r, sync_r};
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern sequencer, shared by generator and checker
  bpws_mode_t  mode;
  logic [3:0]  rep_len;
  logic        run;
  logic [4:0]  pos_r, pos_nxt;
  logic        hi_r, hi_nxt;
  logic [7:0]  rep_r, rep_nxt;
  logic        exp_bit;

  assign mode    = bpws_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign rep_len = ctrl_r[CTRL_LEN_LSB +: 4];
  assign run     = ctrl_r[CTRL_EN_BIT];

  // Top bit index of a repetitive pattern: length field plus sixteen
  function automatic logic [4:0] rep_top(input logic [3:0] len);
    rep_top = REP_TOP_BASE + {1'b0, len};
  endfunction

  always_comb
  begin
    pos_nxt = pos_r;
    hi_nxt  = hi_r;
    rep_nxt = rep_r;
    if (!run)
    begin
      pos_nxt = 5'h00;
      hi_nxt  = 1'b0;
      rep_nxt = 8'h00;
    end
    else if (mode == BPWS_ALT)
    begin
      if (pos_r == HALF_TOP)
      begin
        pos_nxt = 5'h00;
        if (rep_r == cnt_r)
        begin
          rep_nxt = 8'h00;
          hi_nxt  = !hi_r;
        end
        else
          rep_nxt = rep_r + 8'h01;
      end
      else
        pos_nxt = pos_r + 5'h01;
    end
    else
    begin
      hi_nxt  = 1'b0;
      rep_nxt = 8'h00;
      if (pos_r >= rep_top(rep_len))
        pos_nxt = 5'h00;
      else
        pos_nxt = pos_r + 5'h01;
    end
  end

  // Low word from bit 0, high word from bit 16, LSB first
  assign exp_bit = (mode == BPWS_ALT && hi_r) ? bits[HIGH_BASE + pos_r]
                                              : bits[pos_r];

  ////////////////////////////////////////////////////////////////////////
  // Receive checker on the same sequence
  logic [5:0] good_r, good_nxt;

  always_comb
  begin
    tx_nxt     = run ? exp_bit : 1'b0;
    sync_nxt   = sync_r;
    good_nxt   = good_r;
    rx_err_nxt = 1'b0;
    if (!run)
    begin
      sync_nxt = 1'b0;
      good_nxt = 6'h00;
    end
    else if (rx_s_r == exp_bit)
    begin
      if (good_r != 6'h20)
        good_nxt = good_r + 6'h01;
      if (good_r == 6'h1F)
        sync_nxt = 1'b1;
    end
    else
    begin
      good_nxt   = 6'h00;
      rx_err_nxt = sync_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r   <= CTRL_RST;
      cnt_r    <= COUNT_RST;
      rdata_r  <= 8'h00;
      sel_st_r <= 1'b0;
      pos_r    <= 5'h00;
      hi_r     <= 1'b0;
      rep_r    <= 8'h00;
      rx_m_r   <= 1'b0;
      rx_s_r   <= 1'b0;
      sync_r   <= 1'b0;
      good_r   <= 6'h00;
      rx_err_r <= 1'b0;
      tx_r     <= 1'b0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      cnt_r    <= cnt_nxt;
      rdata_r  <= rdata_nxt;
      sel_st_r <= sel_st_nxt;
      pos_r    <= pos_nxt;
      hi_r     <= hi_nxt;
      rep_r    <= rep_nxt;
      rx_m_r   <= rx_bit;
      rx_s_r   <= rx_m_r;
      sync_r   <= sync_nxt;
      good_r   <= good_nxt;
      rx_err_r <= rx_err_nxt;
      tx_r     <= tx_nxt;
    end
  end

  // Store read data is itself registered, so the mux adds no latency
  assign rdata   = sel_st_r ? st_rdata : rdata_r;
  assign tx_bit  = tx_r;
  assign rx_sync = sync_r;
  assign rx_err  = rx_err_r;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_HALF_FLIP: assert property (@(posedge clk) disable iff (srst)
    (run && mode == BPWS_ALT && $past(run) && pos_r == HALF_TOP && rep_r == cnt_r)
      |=> (hi_r != $past(hi_r)))
    else $error("half did not flip after count");
  AST_HALF_HOLD: assert property (@(posedge clk) disable iff (srst)
    (run && mode == BPWS_ALT && rep_r != cnt_r) |=> (hi_r == $past(hi_r)))
    else $error("half flipped early");
  AST_REP_IGN: assert property (@(posedge clk) disable iff (srst)
    (run && mode != BPWS_ALT) |=> (rep_r == 8'h00 && !hi_r))
    else $error("repeat count used outside alternating mode");
  AST_REP_WRAP: assert property (@(posedge clk) disable iff (srst)
    (run && mode == BPWS_REP && $stable(ctrl_r) && pos_r == rep_top(rep_len)) |=> pos_r == 5'h00)
    else $error("repetitive pattern did not wrap at top bit");
  AST_LOW_FIRST: assert property (@(posedge clk) disable iff (srst)
    (run && mode == BPWS_ALT && !hi_r) |=> (tx_bit == $past(bits[pos_r])))
    else $error("low word bit order wrong");
  AST_HIGH_FIRST: assert property (@(posedge clk) disable iff (srst)
    (run && mode == BPWS_ALT && hi_r && pos_r == 5'h00) |=> (tx_bit == $past(bits[16])))
    else $error("high word does not start at bit 16");
  // Write to a store byte, then a read of the same byte in the very next cycle
  sequence s_store_write;
    wr && is_st;
  endsequence
  sequence s_store_read_back;
    rd && is_st && !wr && addr == $past(addr);
  endsequence
  AST_READBACK: assert property (@(posedge clk) disable iff (srst)
    (s_store_write ##1 s_store_read_back) |=> rdata == $past(wdata, 2))
    else $error("store byte read back wrong");
  AST_SYNC: assert property (@(posedge clk) disable iff (srst)
    (run && $past(run) && !$past(sync_r) && sync_r) |-> $past(good_r) == 6'h1F)
    else $error("sync without 32 matching bits");
endmodule // bpws_top
`default_nettype wire

// ==== dv/test_bpws_top.sv ====
// Self-checking bench for the pattern word store and its stream
`timescale 1ns/1ns
`default_nettype none
module test_bpws_top;
  import bpws_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        tx_bit;
  logic        rx_bit = 1'b0;
  logic        rx_sync;
  logic        rx_err;
  logic        hit;
  logic [31:0] pat;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  bpws_top bpws_top_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .tx_bit(tx_bit), .rx_bit(rx_bit),
    .rx_sync(rx_sync), .rx_err(rx_err));

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One idle cycle after each strobe keeps every signal to one update per step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    check(32'(rdata), 32'(exp));
  endtask

  task automatic load(input logic [31:0] v);
    pat = v;
    for (int i = 0; i < 4; i++)
      wr_reg(OFF_BYTE0 + 8'(i), v[8*i +: 8]);
  endtask

  // Entered right after the edge that takes the run bit
  task automatic run_chk(input int n, input bit alt, input int c, input int per);
    int idx;
    @(posedge clk);
    for (int p = 0; p < n; p++)
    begin
      @(negedge clk);
      idx = alt ? ((p / (16 * (c + 1))) % 2) * 16 + p % 16 : p % per;
      check(32'(tx_bit), 32'(pat[idx]));
    end
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_total++;
      close_out();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd_reg(OFF_BYTE0 + 8'(i), BYTE_RST);
    load(32'hC3A5_1E81);
    wr_reg(8'h50, 8'hFF);
    rd_reg(8'h50, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(OFF_BYTE0 + 8'(i), pat[8*i +: 8]);
      rd_reg(OFF_BYTE0 + 8'(i), pat[8*i +: 8]);
    end
    // Back-to-back write then read of one store byte, no idle cycle between
    @(posedge clk);
    addr  <= OFF_BYTE2;
    wdata <= 8'h7E;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    @(negedge clk);
    check(32'(rdata), 32'h7E);
    pat[23:16] = 8'h7E;
    // Alternating mode, repeat count at zero and above
    for (int c = 0; c < 3; c++)
    begin
      wr_reg(OFF_CTRL, 8'h00);
      wr_reg(OFF_COUNT, 8'(c));
      wr_reg(OFF_CTRL, 8'h42);
      run_chk(64 * (c + 1), 1'b1, c, 0);
    end
    // Repetitive mode, shortest and longest length; count must not matter
    for (int len = 0; len < 16; len += 15)
    begin
      wr_reg(OFF_CTRL, 8'h00);
      wr_reg(OFF_CTRL, 8'h41 | 8'(len << 2));
      run_chk(2 * (17 + len), 1'b0, 2, 17 + len);
    end
    // Receiver locks onto an all-ones alternating stream and flags a bad bit
    wr_reg(OFF_CTRL, 8'h00);
    load(32'hFFFF_FFFF);
    rx_bit <= 1'b1;
    wr_reg(OFF_CTRL, 8'h42);
    for (int k = 0; k < 60 && rx_sync !== 1'b1; k++)
      @(negedge clk);
    check(32'(rx_sync), 32'h1);
    rd_reg(OFF_STATUS, 8'h01);
    @(posedge clk);
    rx_bit <= 1'b0;
    @(posedge clk);
    rx_bit <= 1'b1;
    hit = 1'b0;
    repeat (6)
    begin
      @(negedge clk);
      hit = hit | rx_err;
    end
    check(32'(hit), 32'h1);
    // A stream that never matches must not lock
    wr_reg(OFF_CTRL, 8'h00);
    load(32'h0000_0000);
    wr_reg(OFF_CTRL, 8'h42);
    repeat (80) @(negedge clk);
    check(32'(rx_sync), 32'h0);
    close_out();
  end
endmodule // test_bpws_top
`default_nettype wire
